//--- logic/anp_partner_status.sv
// anp_partner_status: per-port read-only auto-negotiation partner
// ability and expansion status, with control, interrupt status and
// interrupt mask, all behind an Avalon-MM slave with waitrequest.
// assumes negotiation strobes and levels arrive on clk, no crossing.
//
// Operation
// - ability bit 15 reads whether the partner can send multiple pages.
// - bit 14 reads the partner acknowledge and bit 13 its remote fault.
// - bit 11 reads partner asymmetric pause, reset value one.
// - bit 10 reads partner symmetric pause request, reset value zero.
// - bit 9 reads partner 100BASE-T4 ability, reset value zero.
// - bits 8 to 5 read the four 100/10 duplex abilities, each reset one.
// - bits 4 to 0 hold the partner selector; non 00001 flags a mismatch.
// - selectors 00000, 11111 and other unassigned codes are reserved.
// - expansion bit 5 mirrors base_page, only while alternate mode is on.
// - expansion bit 4 reads one once a parallel detection fault occurred.
// - expansion bit 3 reads whether the partner is next page able.
// - expansion bit 1 flags a newly loaded page and clears on read.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps

module anp_partner_status import anp_pkg::*; #(
  parameter int unsigned LCW_W = ANP_LCW_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ANP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ANP_DATA_W-1:0] avs_writedata,
  input wire logic [ANP_BE_W-1:0] avs_byteenable,
  output logic [ANP_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic page_valid,
  input wire logic page_is_base,
  input wire logic [LCW_W-1:0] page_word,
  input wire logic base_page_var,
  input wire logic pd_fault_evt,
  input wire logic an_restart,
  output logic irq,
  output logic lp_sel_mismatch
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic waitreq;
    logic [ANP_DATA_W-1:0] rdata;
    logic rd_pr;
    logic alt_np_en;
    logic base_page;
    logic pd_fault;
    logic pg_rcvd;
    logic [ANP_IRQ_W-1:0] irq_sts;
    logic [ANP_IRQ_W-1:0] irq_mask;
    logic irq;
    logic sel_mismatch;
  } anp_bank_state_s;

  // waitrequest idles high so nothing completes before decode
  localparam anp_bank_state_s BANK_RST = '{
    waitreq: 1'b1,
    rdata: '0,
    rd_pr: 1'b0,
    alt_np_en: 1'b0,
    base_page: 1'b0,
    pd_fault: 1'b0,
    pg_rcvd: 1'b0,
    irq_sts: '0,
    irq_mask: ANP_IRQ_MASK_RST,
    irq: 1'b0,
    sel_mismatch: 1'b0
  };

  anp_bank_state_s st_ff;
  anp_bank_state_s nxt_st;

  logic [LCW_W-1:0] cap_ability;
  logic cap_sel_ok;
  logic cap_sel_rsvd;
  logic cap_base_loaded;
  logic cap_page_loaded;

  logic [ANP_IDX_W-1:0] idx;
  logic req_start;
  logic req_done;
  logic [ANP_DATA_W-1:0] rd_word;
  logic [ANP_IRQ_W-1:0] evt;
  logic [ANP_IRQ_W-1:0] w1c;
  logic [ANP_DATA_W-1:0] ctrl_word;
  logic [ANP_DATA_W-1:0] mask_word;

  // ----------------------------------------------------------------
  // base page capture
  // ----------------------------------------------------------------
  anp_lcw_capture #(
    .LCW_W(LCW_W)
  ) u_capture (
    .clk(clk),
    .srst(srst),
    .page_valid(page_valid),
    .page_is_base(page_is_base),
    .page_word(page_word),
    .an_restart(an_restart),
    .ability(cap_ability),
    .sel_ok(cap_sel_ok),
    .sel_rsvd(cap_sel_rsvd),
    .base_loaded(cap_base_loaded),
    .page_loaded(cap_page_loaded)
  );

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------

  // ability word, upper half reserved and reading zero
  function automatic logic [31:0] ability_view(
    input logic [LCW_W-1:0] ab);
    logic [31:0] w;
    w = '0;
    w[ANP_LP_NP_BIT] = ab[ANP_LP_NP_BIT];
    w[ANP_LP_ACK_BIT] = ab[ANP_LP_ACK_BIT];
    w[ANP_LP_RF_BIT] = ab[ANP_LP_RF_BIT];
    w[ANP_LP_ASYM_BIT] = ab[ANP_LP_ASYM_BIT];
    w[ANP_LP_PAUSE_BIT] = ab[ANP_LP_PAUSE_BIT];
    w[ANP_LP_T4_BIT] = ab[ANP_LP_T4_BIT];
    w[ANP_LP_TX_FD_BIT] = ab[ANP_LP_TX_FD_BIT];
    w[ANP_LP_TX_HD_BIT] = ab[ANP_LP_TX_HD_BIT];
    w[ANP_LP_10_FD_BIT] = ab[ANP_LP_10_FD_BIT];
    w[ANP_LP_10_HD_BIT] = ab[ANP_LP_10_HD_BIT];
    w[ANP_SEL_W-1:0] = ab[ANP_SEL_W-1:0];
    return w;
  endfunction : ability_view

  // bus index from the byte address, low two bits ignored
  assign idx = avs_address[ANP_IDX_W+ANP_IDX_LSB-1:ANP_IDX_LSB];

  // control word shows the alternate enable and selector health
  always_comb begin
    ctrl_word = '0;
    ctrl_word[ANP_CTRL_ALT_NP_EN] = st_ff.alt_np_en;
    ctrl_word[ANP_CTRL_SEL_RSVD] = cap_sel_rsvd;
    ctrl_word[ANP_CTRL_SEL_BAD] = ~cap_sel_ok;
    mask_word = '0;
    mask_word[ANP_IRQ_W-1:0] = st_ff.irq_mask;
  end

  // read mux; unmapped indices read as zero
  always_comb begin
    rd_word = '0;
    unique case (idx)
      ANP_IDX_LP_ABILITY: begin
        rd_word = ability_view(cap_ability);
      end
      ANP_IDX_EXPANSION: begin
        // base page only meaningful in alternate next page mode
        rd_word[ANP_EXP_BASE_PAGE] = st_ff.base_page &
                                     st_ff.alt_np_en;
        rd_word[ANP_EXP_PD_FAULT] = st_ff.pd_fault;
        rd_word[ANP_EXP_LP_NP_ABLE] = cap_ability[ANP_LP_NP_BIT];
        rd_word[ANP_EXP_PAGE_RCVD] = st_ff.pg_rcvd;
      end
      ANP_IDX_CTRL: begin
        rd_word = ctrl_word;
      end
      ANP_IDX_IRQ_STS: begin
        rd_word[ANP_IRQ_W-1:0] = st_ff.irq_sts;
      end
      ANP_IDX_IRQ_MASK: begin
        rd_word = mask_word;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------

  // one wait state: start on the first edge, complete on the next
  assign req_start = (avs_read | avs_write) & st_ff.waitreq;
  assign req_done = (avs_read | avs_write) & ~st_ff.waitreq;

  // event sources for the interrupt status
  always_comb begin
    evt = '0;
    evt[ANP_IRQ_PAGE] = cap_page_loaded;
    evt[ANP_IRQ_PDF] = pd_fault_evt;
    evt[ANP_IRQ_SEL] = cap_base_loaded & ~cap_sel_ok;
  end

  // write-one-to-clear bits, taken only at the completing edge
  always_comb begin
    w1c = '0;
    if (req_done && avs_write && idx == ANP_IDX_IRQ_STS &&
        avs_byteenable[0]) begin
      w1c = avs_writedata[ANP_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // waitrequest drops for exactly one cycle per request
    nxt_st.waitreq = 1'b1;
    if (req_start) begin
      nxt_st.waitreq = 1'b0;
      nxt_st.rdata = avs_read ? rd_word : '0;
      // remember whether the returned word carried the page flag
      nxt_st.rd_pr = avs_read && (idx == ANP_IDX_EXPANSION) &&
                     st_ff.pg_rcvd;
    end

    // control and mask take write data here; interrupt status takes only the w1c clears above
    if (req_done && avs_write) begin
      if (idx == ANP_IDX_CTRL) begin
        ctrl_word_merge(nxt_st.alt_np_en);
      end
      if (idx == ANP_IDX_IRQ_MASK) begin
        nxt_st.irq_mask = mask_merge();
      end
    end

    // base page variable tracked every cycle
    nxt_st.base_page = base_page_var;

    // parallel detection fault stays until a restart; set wins
    if (an_restart) begin
      nxt_st.pd_fault = 1'b0;
    end
    if (pd_fault_evt) begin
      nxt_st.pd_fault = 1'b1;
    end

    // page received clears only if the read actually returned it,
    // so a page landing during the read is never swallowed
    if (req_done && avs_read && idx == ANP_IDX_EXPANSION &&
        st_ff.rd_pr) begin
      nxt_st.pg_rcvd = 1'b0;
    end
    if (an_restart) begin
      nxt_st.pg_rcvd = 1'b0;
    end
    if (cap_page_loaded) begin
      nxt_st.pg_rcvd = 1'b1;
    end

    // sticky interrupt status, new events beat the clear
    nxt_st.irq_sts = (st_ff.irq_sts & ~w1c) | evt;
    nxt_st.irq = |(nxt_st.irq_sts & nxt_st.irq_mask);

    // hint to the negotiation logic that the selector will not match
    nxt_st.sel_mismatch = ~cap_sel_ok;
  end

  // control write keeps the enable, status bits are read-only
  function automatic void ctrl_word_merge(output logic en);
    logic [31:0] m;
    m = anp_be_merge(ctrl_word, avs_writedata, avs_byteenable);
    en = m[ANP_CTRL_ALT_NP_EN];
  endfunction : ctrl_word_merge

  // mask write honours byte enables
  function automatic logic [ANP_IRQ_W-1:0] mask_merge();
    logic [31:0] m;
    m = anp_be_merge(mask_word, avs_writedata, avs_byteenable);
    return m[ANP_IRQ_W-1:0];
  endfunction : mask_merge

  // ----------------------------------------------------------------
  // timing notes
  // ----------------------------------------------------------------
  // reset: waitrequest leaves reset high,
  //   so a request raised right after
  //   release starts at the next edge.
  //
  // bus: the read word is frozen at the
  //   start edge and readdata stands
  //   through the wait state.
  //   one wait state per access; a request
  //   held past completion starts again one
  //   edge later as a second access.
  //   writes land at the completing edge
  //   only, so each is applied once.
  //
  // clear on read: the page flag clears
  //   only if the returned word carried it;
  //   a page landing between start and
  //   completion stays flagged.
  //   one extra flop buys no lost pages.
  //
  // interrupts: status bits are sticky and
  //   an event wins over a same-cycle clear.
  //   only byte lane 0 carries clear bits.
  //   irq uses the next status and mask, so
  //   unmasking a pending bit raises irq at
  //   the edge that completes the write.
  //
  // selector health: the mismatch output
  //   and the bad selector event trail a
  //   base page by two edges.
  //   a restart marks the selector healthy.
  //
  // byte enables: control and mask writes
  //   merge lane by lane; read-only control
  //   bits never take write data.
  //
  // expansion bit 5 is gated on read
  //   only; its flop tracks every cycle.
  //
  // limitations: negotiation inputs must
  //   already be on clk; none is resynced.
  //   only the latest base page is held;
  //   next page words are flagged, not kept.
  //   the parallel detection fault holds
  //   until restart or reset, not on read.
  //   writes to ability, expansion or unmapped
  //   space are answered but change nothing.

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= BANK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state flops
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.waitreq;
  assign irq = st_ff.irq;
  assign lp_sel_mismatch = st_ff.sel_mismatch;

endmodule : anp_partner_status

//--- logic/anp_pkg.sv
// anp_pkg: shared constants, register map and helpers for the
// auto-negotiation partner ability and expansion status bank.
// assumes a 32-bit Avalon-MM register port with byte addresses.

package anp_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ANP_DATA_W = 32;
  localparam int unsigned ANP_BE_W = 4;
  localparam int unsigned ANP_ADDR_W = 12;
  localparam int unsigned ANP_IDX_W = 10;
  localparam int unsigned ANP_IDX_LSB = 2;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] ANP_IDX_LP_ABILITY = 10'h065;
  localparam logic [9:0] ANP_IDX_EXPANSION = 10'h066;
  localparam logic [9:0] ANP_IDX_CTRL = 10'h068;
  localparam logic [9:0] ANP_IDX_IRQ_STS = 10'h069;
  localparam logic [9:0] ANP_IDX_IRQ_MASK = 10'h06A;

  // ----------------------------------------------------------------
  // partner base page ability word layout
  // ----------------------------------------------------------------
  localparam int unsigned ANP_LCW_W = 16;
  localparam int unsigned ANP_LP_NP_BIT = 15;
  localparam int unsigned ANP_LP_ACK_BIT = 14;
  localparam int unsigned ANP_LP_RF_BIT = 13;
  localparam int unsigned ANP_LP_ASYM_BIT = 11;
  localparam int unsigned ANP_LP_PAUSE_BIT = 10;
  localparam int unsigned ANP_LP_T4_BIT = 9;
  localparam int unsigned ANP_LP_TX_FD_BIT = 8;
  localparam int unsigned ANP_LP_TX_HD_BIT = 7;
  localparam int unsigned ANP_LP_10_FD_BIT = 6;
  localparam int unsigned ANP_LP_10_HD_BIT = 5;
  localparam int unsigned ANP_SEL_W = 5;
  localparam logic [15:0] ANP_LP_ABILITY_RST = 16'h09E1;
  localparam logic [4:0] ANP_SEL_802_3 = 5'h01;
  localparam logic [4:0] ANP_SEL_802_9 = 5'h02;

  // ----------------------------------------------------------------
  // expansion, control and interrupt layouts
  // ----------------------------------------------------------------
  localparam int unsigned ANP_EXP_BASE_PAGE = 5;
  localparam int unsigned ANP_EXP_PD_FAULT = 4;
  localparam int unsigned ANP_EXP_LP_NP_ABLE = 3;
  localparam int unsigned ANP_EXP_PAGE_RCVD = 1;
  localparam int unsigned ANP_CTRL_ALT_NP_EN = 0;
  localparam int unsigned ANP_CTRL_SEL_RSVD = 8;
  localparam int unsigned ANP_CTRL_SEL_BAD = 9;
  localparam int unsigned ANP_IRQ_W = 3;
  localparam int unsigned ANP_IRQ_PAGE = 0;
  localparam int unsigned ANP_IRQ_PDF = 1;
  localparam int unsigned ANP_IRQ_SEL = 2;
  localparam logic [2:0] ANP_IRQ_MASK_RST = 3'h0;

  // any selector other than the two assigned codes is reserved
  function automatic logic anp_sel_reserved(input logic [4:0] sel);
    return !((sel == ANP_SEL_802_3) || (sel == ANP_SEL_802_9));
  endfunction : anp_sel_reserved

  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] anp_be_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < ANP_BE_W; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : anp_be_merge

endpackage : anp_pkg

//--- logic/anp_lcw_capture.sv
// anp_lcw_capture: holds the last base page link code word received
// from the link partner and classifies its selector.
// assumes page strobes come from negotiation logic on the same clock.
`timescale 1ns/1ps

module anp_lcw_capture import anp_pkg::*; #(
  parameter int unsigned LCW_W = ANP_LCW_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic page_valid,
  input wire logic page_is_base,
  input wire logic [LCW_W-1:0] page_word,
  input wire logic an_restart,
  output logic [LCW_W-1:0] ability,
  output logic sel_ok,
  output logic sel_rsvd,
  output logic base_loaded,
  output logic page_loaded
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [LCW_W-1:0] ability;
    logic sel_ok;
    logic sel_rsvd;
    logic base_loaded;
    logic page_loaded;
  } anp_cap_state_s;

  localparam anp_cap_state_s CAP_RST = '{
    ability: LCW_W'(ANP_LP_ABILITY_RST),
    sel_ok: 1'b1,
    sel_rsvd: 1'b0,
    base_loaded: 1'b0,
    page_loaded: 1'b0
  };

  anp_cap_state_s st_ff;
  anp_cap_state_s nxt_st;
  logic [ANP_SEL_W-1:0] sel;

  assign sel = page_word[ANP_SEL_W-1:0];

  // next pages only raise the loaded strobe, base pages refresh fields
  always_comb begin
    nxt_st = st_ff;
    nxt_st.base_loaded = 1'b0;
    nxt_st.page_loaded = page_valid;
    if (an_restart) begin
      nxt_st.ability = CAP_RST.ability;
      nxt_st.sel_ok = 1'b1;
      nxt_st.sel_rsvd = 1'b0;
    end
    if (page_valid && page_is_base) begin
      nxt_st.ability = page_word;
      nxt_st.sel_ok = (sel == ANP_SEL_802_3);
      nxt_st.sel_rsvd = anp_sel_reserved(sel);
      nxt_st.base_loaded = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= CAP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ability = st_ff.ability;
  assign sel_ok = st_ff.sel_ok;
  assign sel_rsvd = st_ff.sel_rsvd;
  assign base_loaded = st_ff.base_loaded;
  assign page_loaded = st_ff.page_loaded;

endmodule : anp_lcw_capture

//--- bench/anp_partner_status_props.sv
// anp_partner_status_props: concurrent checks on the register port,
// the selector flag and the interrupt of the partner status bank.
// assumes one clk domain and srst synchronous, active high.
`timescale 1ns/1ps

module anp_partner_status_props import anp_pkg::*; #(
  parameter int unsigned LCW_W = ANP_LCW_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ANP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ANP_DATA_W-1:0] avs_writedata,
  input wire logic [ANP_BE_W-1:0] avs_byteenable,
  input wire logic [ANP_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic page_valid,
  input wire logic page_is_base,
  input wire logic [LCW_W-1:0] page_word,
  input wire logic base_page_var,
  input wire logic pd_fault_evt,
  input wire logic an_restart,
  input wire logic irq,
  input wire logic lp_sel_mismatch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic [9:0] idx;
  logic start;
  logic mapped;
  logic base_pg;
  assign idx = avs_address[11:2];
  assign start = (avs_read || avs_write) && avs_waitrequest;
  assign mapped = idx inside {ANP_IDX_LP_ABILITY, ANP_IDX_EXPANSION,
                              ANP_IDX_CTRL, ANP_IDX_IRQ_STS, ANP_IDX_IRQ_MASK};
  assign base_pg = page_valid && page_is_base && !an_restart;

  a_wait_one_cycle: assert property (start |=> !avs_waitrequest)
    else $error("waitrequest not low one cycle after request");
  a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait_high: assert property (!(avs_read || avs_write) &&
      !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  a_ability_rsvd_zero: assert property (
      start && avs_read && idx == ANP_IDX_LP_ABILITY
      |=> avs_readdata[31:16] == 16'h0000)
    else $error("ability upper bits not zero");
  a_expn_rsvd_zero: assert property (
      start && avs_read && idx == ANP_IDX_EXPANSION
      |=> avs_readdata[31:6] == 26'h0 && !avs_readdata[2] && !avs_readdata[0])
    else $error("expansion reserved bits not zero");
  a_unmapped_zero: assert property (
      start && avs_read && !mapped |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_sel_flag_follows: assert property (
      base_pg ##1 !(page_valid && page_is_base) && !an_restart
      |=> lp_sel_mismatch == ($past(page_word[4:0], 2) != 5'h01))
    else $error("selector flag wrong after base page");
  a_sel_flag_holds: assert property (
      !($past(page_valid) || $past(page_valid, 2) ||
        $past(an_restart) || $past(an_restart, 2))
      |-> $stable(lp_sel_mismatch))
    else $error("selector flag moved without a page");
  // an interrupt may only rise after an event or a register write
  a_irq_has_cause: assert property (
      $rose(irq) |-> $past(page_valid) || $past(page_valid, 2) ||
      $past(page_valid, 3) || $past(pd_fault_evt) || $past(avs_write))
    else $error("interrupt rose without a cause");
endmodule : anp_partner_status_props

bind anp_partner_status anp_partner_status_props #(.LCW_W(LCW_W)) props_u (
  .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .page_valid(page_valid),
  .page_is_base(page_is_base), .page_word(page_word),
  .base_page_var(base_page_var), .pd_fault_evt(pd_fault_evt),
  .an_restart(an_restart), .irq(irq), .lp_sel_mismatch(lp_sel_mismatch));

//--- bench/anp_link_partner.sv
// anp_link_partner: remote link partner handing complete pages over.
// assumes the caller is aligned to a rising edge of clk.
`timescale 1ns/1ps

module anp_link_partner import anp_pkg::*; (
  input wire logic clk,
  output logic page_valid,
  output logic page_is_base,
  output logic [ANP_LCW_W-1:0] page_word
);
  initial begin
    page_valid = 1'b0;
    page_is_base = 1'b0;
    page_word = 16'h0000;
  end

  // one-cycle page strobe; word inverted after so stale data never matches
  // reserved selectors only go out when a caller asks for them
  task automatic send_page(input logic base, input logic [15:0] w);
    page_valid <= 1'b1;
    page_is_base <= base;
    page_word <= w;
    @(posedge clk);
    page_valid <= 1'b0;
    page_is_base <= ~base;
    page_word <= ~w;
    @(posedge clk);
  endtask : send_page
endmodule : anp_link_partner

//--- bench/test_autoneg_partner_ability_status.sv
// test_autoneg_partner_ability_status: self-checking bench of the bank.
// assumes the checker is bound and the partner model drives pages.
`timescale 1ns/1ps

module test_autoneg_partner_ability_status import anp_pkg::*; ;
  typedef struct packed {logic [15:0] word; logic mism;} anp_row_s;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic base_page_var = 1'b0;
  logic pd_fault_evt = 1'b0;
  logic an_restart = 1'b0;
  logic irq;
  logic lp_sel_mismatch;
  logic page_valid;
  logic page_is_base;
  logic [15:0] page_word;
  logic [31:0] d;
  int fail_count = 0;
  int n_tests = 0;
  anp_row_s rows [5] = '{'{16'h8001, 1'b0}, '{16'h4DE2, 1'b1},
    '{16'h2400, 1'b1}, '{16'h0A3F, 1'b1}, '{16'h01C1, 1'b0}};
  logic [9:0] rst_idx [5] = '{ANP_IDX_LP_ABILITY, ANP_IDX_EXPANSION,
    ANP_IDX_CTRL, ANP_IDX_IRQ_STS, ANP_IDX_IRQ_MASK};

  always #5 clk = ~clk;

  anp_partner_status dut_u (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .page_valid(page_valid), .page_is_base(page_is_base),
    .page_word(page_word), .base_page_var(base_page_var),
    .pd_fault_evt(pd_fault_evt), .an_restart(an_restart), .irq(irq),
    .lp_sel_mismatch(lp_sel_mismatch));
  anp_link_partner lp_u (.clk(clk), .page_valid(page_valid),
    .page_is_base(page_is_base), .page_word(page_word));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one avalon access; an extra edge after release avoids re-driving
  task automatic bus_xfer(input logic we, input logic [9:0] idx,
                          input logic [31:0] wd, output logic [31:0] rd);
    avs_address <= {idx, 2'h0};
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus_xfer

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp,
                        input string what);
    logic [31:0] r;
    bus_xfer(1'b0, idx, 32'h0, r);
    check(r, exp, what);
  endtask : rd_chk

  // one-cycle event: 1 for a parallel detection fault, 0 for a restart
  task automatic pulse(input logic pdf);
    if (pdf) pd_fault_evt <= 1'b1;
    else an_restart <= 1'b1;
    @(posedge clk);
    pd_fault_evt <= 1'b0;
    an_restart <= 1'b0;
    @(posedge clk);
  endtask : pulse

  // watchdog well beyond the roughly 180 cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // base pages with every ability bit and each selector class
    foreach (rows[i]) begin
      lp_u.send_page(1'b1, rows[i].word);
      rd_chk(ANP_IDX_LP_ABILITY, {16'h0, rows[i].word},
        "ability");
      rd_chk(ANP_IDX_EXPANSION, {28'h0, rows[i].word[15], 3'h2},
        "exp");
      rd_chk(ANP_IDX_EXPANSION, {28'h0, rows[i].word[15], 3'h0},
        "rd clr");
      check({31'h0, lp_sel_mismatch}, {31'h0, rows[i].mism},
        "sel flag");
      rd_chk(ANP_IDX_CTRL, {22'h0, rows[i].mism,
        !(rows[i].word[4:0] inside {5'h01, 5'h02}), 8'h0}, "ctrl");
      check({31'h0, irq}, 32'h0, "irq masked");
    end
    rd_chk(ANP_IDX_IRQ_STS, 32'h5, "irq sts sel");
    // interrupt raised by unmasking, cleared by write one
    bus_xfer(1'b1, ANP_IDX_IRQ_MASK, 32'h1, d);
    check({31'h0, irq}, 32'h1, "irq page");
    bus_xfer(1'b1, ANP_IDX_IRQ_STS, 32'h7, d);
    check({31'h0, irq}, 32'h0, "irq clear");
    bus_xfer(1'b1, ANP_IDX_IRQ_MASK, 32'h2, d);
    pulse(1'b1);
    check({31'h0, irq}, 32'h1, "irq pd fault");
    rd_chk(ANP_IDX_IRQ_STS, 32'h2, "irq sts");
    // clear bits ride on byte lane 0 only
    avs_byteenable <= 4'hE;
    bus_xfer(1'b1, ANP_IDX_IRQ_STS, 32'h7, d);
    avs_byteenable <= 4'hF;
    rd_chk(ANP_IDX_IRQ_STS, 32'h2, "w1c lane");
    bus_xfer(1'b1, ANP_IDX_IRQ_STS, 32'h7, d);
    bus_xfer(1'b1, ANP_IDX_IRQ_MASK, 32'h0, d);
    // status registers ignore writes; unmapped space reads zero
    bus_xfer(1'b1, ANP_IDX_LP_ABILITY, 32'hFFFFFFFF, d);
    bus_xfer(1'b1, ANP_IDX_EXPANSION, 32'hFFFFFFFF, d);
    rd_chk(ANP_IDX_LP_ABILITY, 32'h01C1, "ro ability");
    rd_chk(10'h3FF, 32'h0, "unmapped");
    // a next page flags arrival but leaves the ability word alone
    lp_u.send_page(1'b0, 16'hFFFF);
    rd_chk(ANP_IDX_LP_ABILITY, 32'h01C1, "next page");
    rd_chk(ANP_IDX_EXPANSION, 32'h12, "np flag");
    rd_chk(ANP_IDX_EXPANSION, 32'h10, "pd sticky");
    // base page bit shows only with alternate mode enabled
    base_page_var <= 1'b1;
    @(posedge clk);
    rd_chk(ANP_IDX_EXPANSION, 32'h10, "alt off");
    bus_xfer(1'b1, ANP_IDX_CTRL, 32'h1, d);
    rd_chk(ANP_IDX_EXPANSION, 32'h30, "alt on");
    // restart returns ability to defaults and clears the fault
    lp_u.send_page(1'b1, 16'h0002);
    pulse(1'b0);
    rd_chk(ANP_IDX_LP_ABILITY, 32'h09E1, "restart");
    rd_chk(ANP_IDX_EXPANSION, 32'h20, "restart exp");
    check({31'h0, lp_sel_mismatch}, 32'h0, "restart sel");
    // reserved ability bit 12 never shows, even when the partner sets it
    lp_u.send_page(1'b1, 16'h1001);
    rd_chk(ANP_IDX_LP_ABILITY, 32'h0001, "rsvd bit");
    // second reset in mid-run, then every register at its reset value
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    base_page_var <= 1'b0;
    @(posedge clk);
    foreach (rst_idx[i])
      rd_chk(rst_idx[i], (i == 0) ? 32'h09E1 : 32'h0,
        "reset");
    check({31'h0, irq}, 32'h0, "reset irq");
    end_of_test();
  end
endmodule : test_autoneg_partner_ability_status
